// ==== pic_controller.sv ====
// Vectored priority interrupt controller with register port and core handshake.
// Contract
// - The non-maskable request outranks all others and is taken whatever the mode or mask.
// - The non-maskable pin requests on the rising or falling edge chosen by one control bit.
// - In levelled mode a core mask level of 7 holds off every source except the non-maskable one.
// - A source whose priority field is 0 is never accepted.
// - Each request line senses low level, falling, rising or both edges as set.
// - Each request line has an enable bit and a cleared bit masks its requests.
// - Request line 6 comes from the internal USB function but behaves like the others.
// - The presented vector address is four times the vector number, zero-extended to 16 bits.
// - The non-maskable request uses vector 7 at 001C and line 0 vector 16 at 0040.
// - Soft transfer end uses vector 24 at 0060 with the third register low field.
// - Timer unit 0 sources share one field and compare A uses vector 32 at 0080.
// - Each line or shared group takes its level from its own 3-bit priority field.
// - In levelled mode a request is taken only when its level exceeds the mask level.
// - Acceptance loads the mask level with the source level, or 7 for non-maskable.
// - Sense codes are 0 low, 1 falling, 2 rising, 3 both; reset gives low and disabled.
// - In levelled mode the highest pending level is served first and table order breaks ties; otherwise table order alone decides.
`timescale 1ns/1ns
`include "pic_regs.svh"
module pic_controller import pic_pkg::*; (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic [4:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic write_i,
  input wire logic read_i,
  output logic [7:0] rdata_o,
  input wire logic nmi_pin_i,
  input wire logic [6:0] ext_line_i,
  input wire logic usb_line_i,
  input wire logic [39:0] periph_req_i,
  input wire logic [2:0] core_mask_i,
  input wire logic core_ibit_i,
  input wire logic ack_i,
  output logic req_o,
  output logic req_nmi_o,
  output logic [7:0] vec_num_o,
  output logic [15:0] vec_addr_o,
  output logic [2:0] req_level_o,
  output logic mask_load_o,
  output logic [2:0] mask_level_o,
  output logic irq_o
);
  // Source groups in fixed table order: first source index, first vector, priority field.
  localparam logic [17:0][5:0] GRP_FIRST = {6'd46, 6'd42, 6'd38, 6'd34, 6'd30, 6'd27,
    6'd24, 6'd20, 6'd16, 6'd11, 6'd10, 6'd9, 6'd8, 6'd6, 6'd4, 6'd2, 6'd1, 6'd0};
  localparam logic [17:0][7:0] GRP_VEC = {8'd104, 8'd88, 8'd84, 8'd80, 8'd72, 8'd68,
    8'd64, 8'd44, 8'd40, 8'd32, 8'd28, 8'd25, 8'd24, 8'd22, 8'd20, 8'd18, 8'd17, 8'd16};
  localparam logic [17:0][4:0] GRP_FIELD = {5'd20, 5'd19, 5'd18, 5'd17, 5'd16, 5'd15,
    5'd14, 5'd12, 5'd11, 5'd10, 5'd9, 5'd6, 5'd5, 5'd4, 5'd3, 5'd2, 5'd1, 5'd0};

  pic_state_t s;
  pic_state_t next_s;
  logic [7:0] line_now;
  logic [7:0] line_pend;
  logic [7:0] line_take;
  logic [47:0] all_pend;
  logic sel_found;
  logic [2:0] sel_lvl;
  logic [5:0] sel_idx;
  logic [2:0] lvl;
  logic any_pend;
  logic nmi_edge_seen;
  logic take_nmi;
  logic take_mask;
  logic [2:0] stat_clr;
  logic [2:0] stat_set;

  // Group that holds a source: the last group whose first index is not above it.
  function automatic logic [4:0] src_group(input logic [5:0] idx);
    src_group = 5'd0;
    for (int g = 1; g < 18; g++) begin
      if (idx >= GRP_FIRST[g]) begin
        src_group = 5'(g);
      end
    end
  endfunction : src_group

  // Vector number: group base plus position inside the group.
  function automatic logic [7:0] src_vector(input logic [5:0] idx);
    logic [4:0] g;
    g = src_group(idx);
    src_vector = GRP_VEC[g] + 8'(idx - GRP_FIRST[g]);
  endfunction : src_vector

  // Even fields sit in bits 6..4 of a priority register, odd fields in bits 2..0.
  function automatic logic [2:0] prio_field(input logic [10:0][7:0] prio,
                                            input logic [4:0] f);
    logic [7:0] r;
    r = prio[f[4:1]];
    prio_field = f[0] ? r[`PIC_PRIO_LO_POS +: 3] : r[`PIC_PRIO_HI_POS +: 3];
  endfunction : prio_field

  // Line 6 is the internal USB request on this clock; pins pass two flip-flops first.
  assign line_now = {s.pin_sync2[6], usb_line_i, s.pin_sync2[5:0]};
  assign all_pend = {periph_req_i, line_pend};

  genvar gl;
  generate
    for (gl = 0; gl < 8; gl++) begin : g_line
      assign line_take[gl] = take_mask && (s.req_src == 6'(gl));
      pic_line_sense u_sense (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .line_i(line_now[gl]),
        .sense_i(s.sense[2 * gl +: 2]),
        .enable_i(s.line_en[gl]),
        .take_i(line_take[gl]),
        .pend_o(line_pend[gl])
      );
    end
  endgenerate

  // Arbitration, handshake, register port and event flags.
  always_comb begin
    next_s = s;
    sel_found = 1'b0;
    sel_lvl = 3'h0;
    sel_idx = 6'h00;
    lvl = 3'h0;
    any_pend = 1'b0;
    // Strict greater-than keeps the lower table index on equal levels.
    for (int i = 0; i < `PIC_NUM_SRC; i++) begin
      lvl = prio_field(s.prio, GRP_FIELD[src_group(6'(i))]);
      any_pend = any_pend | all_pend[i];
      if (all_pend[i] && lvl != 3'h0 &&
          (s.mode2 ? (lvl > core_mask_i) : !core_ibit_i) &&
          (!sel_found || (s.mode2 && lvl > sel_lvl))) begin
        sel_found = 1'b1;
        sel_lvl = lvl;
        sel_idx = 6'(i);
      end
    end

    next_s.nmi_sync1 = nmi_pin_i;
    next_s.nmi_sync2 = s.nmi_sync1;
    next_s.nmi_prev = s.nmi_sync2;
    next_s.pin_sync1 = ext_line_i;
    next_s.pin_sync2 = s.pin_sync1;
    nmi_edge_seen = s.nmi_edge ? (s.nmi_sync2 & ~s.nmi_prev)
                               : (~s.nmi_sync2 & s.nmi_prev);
    take_nmi = (s.hs == PIC_HS_OFFER) && ack_i && s.req_nmi;
    take_mask = (s.hs == PIC_HS_OFFER) && ack_i && !s.req_nmi;
    next_s.nmi_pend = nmi_edge_seen | (s.nmi_pend & ~take_nmi);

    // A fresh choice is presented every offering cycle until the core takes it.
    case (s.hs)
      PIC_HS_IDLE, PIC_HS_OFFER: begin
        if (s.hs == PIC_HS_OFFER && ack_i) begin
          next_s.hs = PIC_HS_SETTLE;
          next_s.req = 1'b0;
          next_s.mask_load = 1'b1;
          next_s.mask_level = s.req_nmi ? `PIC_TOP_LEVEL : s.req_level;
        end else if (s.nmi_pend || sel_found) begin
          next_s.hs = PIC_HS_OFFER;
          next_s.req = 1'b1;
          next_s.req_nmi = s.nmi_pend;
          next_s.req_src = sel_idx;
          next_s.vec_num = s.nmi_pend ? `PIC_NMI_VECTOR : src_vector(sel_idx);
          next_s.vec_addr = s.nmi_pend ? `PIC_NMI_ADDR
                                       : {6'h00, src_vector(sel_idx), 2'b00};
          next_s.req_level = s.nmi_pend ? `PIC_TOP_LEVEL : sel_lvl;
        end else begin
          next_s.hs = PIC_HS_IDLE;
          next_s.req = 1'b0;
        end
      end
      PIC_HS_SETTLE: begin
        // One quiet cycle lets the core apply the new mask before the next offer.
        next_s.hs = PIC_HS_IDLE;
        next_s.mask_load = 1'b0;
      end
      default: begin
        next_s.hs = PIC_HS_IDLE;
        next_s.req = 1'b0;
        next_s.mask_load = 1'b0;
      end
    endcase

    stat_clr = 3'h0;
    if (write_i) begin
      if (addr_i <= `PIC_ADDR_PRIO_LAST) begin
        next_s.prio[addr_i[3:0]] = wdata_i & `PIC_PRIO_WMASK;
      end
      case (addr_i)
        `PIC_ADDR_LINE_EN: next_s.line_en = wdata_i;
        `PIC_ADDR_SENSE_LO: next_s.sense[7:0] = wdata_i;
        `PIC_ADDR_SENSE_HI: next_s.sense[15:8] = wdata_i;
        `PIC_ADDR_SYSCTRL: begin
          next_s.mode2 = wdata_i[`PIC_SYS_MODE_BIT];
          next_s.nmi_edge = wdata_i[`PIC_SYS_EDGE_BIT];
        end
        `PIC_ADDR_STATUS: stat_clr = wdata_i[2:0];
        `PIC_ADDR_IMASK: next_s.imask = wdata_i[2:0];
        default: stat_clr = 3'h0;
      endcase
    end
    // Setting wins over a same-cycle clear so no event is lost.
    stat_set = 3'h0;
    stat_set[`PIC_STAT_NMI_BIT] = take_nmi;
    stat_set[`PIC_STAT_TAKE_BIT] = take_mask;
    stat_set[`PIC_STAT_HELD_BIT] = any_pend & ~sel_found;
    next_s.status = (s.status & ~stat_clr) | stat_set;
    next_s.irq = |(next_s.status & next_s.imask);

    // Read data stands only in the cycle after the read strobe.
    next_s.rdata = 8'h00;
    if (read_i) begin
      if (addr_i <= `PIC_ADDR_PRIO_LAST) begin
        next_s.rdata = s.prio[addr_i[3:0]];
      end
      case (addr_i)
        `PIC_ADDR_LINE_EN: next_s.rdata = s.line_en;
        `PIC_ADDR_SENSE_LO: next_s.rdata = s.sense[7:0];
        `PIC_ADDR_SENSE_HI: next_s.rdata = s.sense[15:8];
        `PIC_ADDR_SYSCTRL: next_s.rdata = {6'h00, s.nmi_edge, s.mode2};
        `PIC_ADDR_STATUS: next_s.rdata = {5'h00, s.status};
        `PIC_ADDR_IMASK: next_s.rdata = {5'h00, s.imask};
        `PIC_ADDR_PENDING: next_s.rdata = line_pend;
        default: next_s.rdata = next_s.rdata;
      endcase
    end
  end

  // Reset takes constants only; priorities start at the top level, lines low and disabled.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      s <= '0;
      s.prio <= {`PIC_NUM_PRIO{`PIC_PRIO_RESET}};
      s.line_en <= `PIC_LINE_EN_RESET;
      s.sense <= `PIC_SENSE_RESET;
      s.mode2 <= `PIC_MODE_RESET;
      s.nmi_edge <= `PIC_NMI_EDGE_RESET;
      s.hs <= PIC_HS_IDLE;
      // Pin synchronisers start at the idle level so no false edge follows reset.
      s.pin_sync1 <= {7{`PIC_LINE_IDLE}};
      s.pin_sync2 <= {7{`PIC_LINE_IDLE}};
    end else begin
      s <= next_s;
    end
  end

  assign rdata_o = s.rdata;
  assign req_o = s.req;
  assign req_nmi_o = s.req_nmi;
  assign vec_num_o = s.vec_num;
  assign vec_addr_o = s.vec_addr;
  assign req_level_o = s.req_level;
  assign mask_load_o = s.mask_load;
  assign mask_level_o = s.mask_level;
  assign irq_o = s.irq;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  sequence offer_taken;
    s.req && ack_i;
  endsequence
  sequence mask_loaded;
    s.mask_load && !s.req && s.mask_level == (s.req_nmi ? 3'h7 : s.req_level);
  endsequence

  a_nmi_first: assert property ((s.nmi_pend && s.hs == PIC_HS_IDLE) |=>
    (s.req && s.req_nmi)) else $error("pending nmi not offered first");
  a_nmi_vector: assert property ((s.req && s.req_nmi) |->
    (s.vec_num == 8'h07 && s.vec_addr == 16'h001C)) else $error("wrong nmi vector");
  a_mask_seven: assert property ((s.req && !s.req_nmi && $past(s.mode2)) |->
    $past(core_mask_i) != 3'h7) else $error("source offered at mask level 7");
  a_level_above: assert property ((s.req && !s.req_nmi && $past(s.mode2)) |->
    s.req_level > $past(core_mask_i)) else $error("level not above mask");
  a_level_zero: assert property ((s.req && !s.req_nmi) |->
    s.req_level != 3'h0) else $error("level 0 source offered");
  a_vec_address: assert property (s.req |->
    s.vec_addr == {6'h00, s.vec_num, 2'b00}) else $error("vector address mismatch");
  a_mask_reload: assert property (offer_taken |=> mask_loaded ##1 !s.mask_load)
    else $error("mask level not loaded after acceptance");
  a_line_enable: assert property ((s.req && !s.req_nmi && s.req_src < 6'd8) |->
    ($past(s.line_en) & (8'h01 << s.req_src[2:0])) != 8'h00)
    else $error("disabled line offered");
  a_irq_level: assert property (irq_o == |(s.status & s.imask))
    else $error("interrupt output disagrees with status");
endmodule : pic_controller

// ==== pic_regs.svh ====
// Register offsets, field positions, reset values and fixed codes of the interrupt controller.
`ifndef PIC_REGS_SVH
`define PIC_REGS_SVH
`define PIC_ADDR_PRIO_LAST 5'h0A
`define PIC_ADDR_LINE_EN 5'h0B
`define PIC_ADDR_SENSE_LO 5'h0C
`define PIC_ADDR_SENSE_HI 5'h0D
`define PIC_ADDR_SYSCTRL 5'h0E
`define PIC_ADDR_STATUS 5'h0F
`define PIC_ADDR_IMASK 5'h10
`define PIC_ADDR_PENDING 5'h11
`define PIC_PRIO_HI_POS 4
`define PIC_PRIO_LO_POS 0
`define PIC_PRIO_WMASK 8'h77
`define PIC_PRIO_RESET 8'h77
`define PIC_LINE_EN_RESET 8'h00
`define PIC_SENSE_RESET 16'h0000
`define PIC_SYS_MODE_BIT 0
`define PIC_SYS_EDGE_BIT 1
`define PIC_MODE_RESET 1'b0
`define PIC_NMI_EDGE_RESET 1'b1
`define PIC_STAT_NMI_BIT 0
`define PIC_STAT_TAKE_BIT 1
`define PIC_STAT_HELD_BIT 2
`define PIC_SENSE_LOW 2'h0
`define PIC_SENSE_FALL 2'h1
`define PIC_SENSE_RISE 2'h2
`define PIC_SENSE_BOTH 2'h3
`define PIC_LINE_IDLE 1'b1
`define PIC_NMI_VECTOR 8'h07
`define PIC_NMI_ADDR 16'h001C
`define PIC_TOP_LEVEL 3'h7
`define PIC_NUM_SRC 48
`define PIC_NUM_PRIO 11
`endif

// ==== pic_pkg.sv ====
// Types shared by the interrupt controller modules.
package pic_pkg;
  typedef enum logic [1:0] {
    PIC_HS_IDLE = 2'b00,
    PIC_HS_OFFER = 2'b01,
    PIC_HS_SETTLE = 2'b10
  } pic_hs_t;

  typedef struct packed {
    logic prev;
    logic latch;
  } pic_sense_t;

  typedef struct packed {
    logic [10:0][7:0] prio;
    logic [7:0] line_en;
    logic [15:0] sense;
    logic mode2;
    logic nmi_edge;
    logic [2:0] status;
    logic [2:0] imask;
    logic nmi_sync1;
    logic nmi_sync2;
    logic nmi_prev;
    logic nmi_pend;
    logic [6:0] pin_sync1;
    logic [6:0] pin_sync2;
    pic_hs_t hs;
    logic req;
    logic req_nmi;
    logic [5:0] req_src;
    logic [7:0] vec_num;
    logic [15:0] vec_addr;
    logic [2:0] req_level;
    logic mask_load;
    logic [2:0] mask_level;
    logic [7:0] rdata;
    logic irq;
  } pic_state_t;
endpackage : pic_pkg

// ==== pic_line_sense.sv ====
// Sense and pending logic of one request line.
`timescale 1ns/1ns
`include "pic_regs.svh"
module pic_line_sense import pic_pkg::*; (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic line_i,
  input wire logic [1:0] sense_i,
  input wire logic enable_i,
  input wire logic take_i,
  output logic pend_o
);
  pic_sense_t s;
  pic_sense_t next_s;
  logic edge_seen;

  // Edge detection against the previous sample; a new edge beats a take in the same cycle.
  always_comb begin
    next_s = s;
    next_s.prev = line_i;
    case (sense_i)
      `PIC_SENSE_FALL: edge_seen = s.prev & ~line_i;
      `PIC_SENSE_RISE: edge_seen = ~s.prev & line_i;
      `PIC_SENSE_BOTH: edge_seen = s.prev ^ line_i;
      default: edge_seen = 1'b0;
    endcase
    if (sense_i == `PIC_SENSE_LOW) begin
      next_s.latch = 1'b0;
    end else begin
      next_s.latch = (enable_i & edge_seen) | (s.latch & ~take_i);
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      s.prev <= `PIC_LINE_IDLE;
      s.latch <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  // Level sense follows the line every clock; a cleared enable hides both kinds.
  assign pend_o = enable_i & ((sense_i == `PIC_SENSE_LOW) ? ~line_i : s.latch);

  a_edge_latch: assert property (@(posedge clock_i) disable iff (reset_i)
    (enable_i && sense_i == `PIC_SENSE_FALL && s.prev && !line_i) |=> s.latch)
    else $error("falling edge was not latched");
  a_latch_hold: assert property (@(posedge clock_i) disable iff (reset_i)
    (s.latch && !take_i && sense_i != `PIC_SENSE_LOW) |=> s.latch)
    else $error("pending edge lost before it was taken");
endmodule : pic_line_sense

// ==== pic_core_model.sv ====
// Behavioural processor core that acknowledges vectored requests from the controller.
`timescale 1ns/1ns
module pic_core_model (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic req_i,
  input wire logic [7:0] vec_i,
  input wire logic [15:0] addr_i,
  input wire logic mask_load_i,
  input wire logic [2:0] mask_level_i,
  input wire logic [1:0] delay_i,
  input wire logic mask_wr_i,
  input wire logic [2:0] mask_val_i,
  output logic ack_o,
  output logic [2:0] mask_o,
  output logic taken_o,
  output logic [7:0] vec_o,
  output logic [15:0] addr_o
);
  logic [1:0] wait_q;

  // A request is answered after delay_i idle cycles; the vector counts only at the
  // edge that samples the acknowledge, because the offer may still improve before it.
  always_ff @(posedge clock_i) begin
    taken_o <= ack_o & req_i & ~reset_i;
    ack_o <= 1'b0;
    if (ack_o & req_i) begin
      vec_o <= vec_i;
      addr_o <= addr_i;
    end
    if (reset_i) begin
      wait_q <= 2'h0;
    end else if (req_i & ~ack_o) begin
      if (wait_q == delay_i) begin
        ack_o <= 1'b1;
        wait_q <= 2'h0;
      end else begin
        wait_q <= wait_q + 2'h1;
      end
    end else begin
      wait_q <= 2'h0;
    end
  end

  // The mask follows the load pulse, so only higher levels can nest afterwards.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      mask_o <= 3'h7;
    end else if (mask_load_i) begin
      mask_o <= mask_level_i;
    end else if (mask_wr_i) begin
      mask_o <= mask_val_i;
    end
  end
endmodule : pic_core_model

// ==== priority_interrupt_controller_tb_top.sv ====
// Self-checking bench for the priority interrupt controller with a core model.
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("Error %s expected %0h seen %0h", n, e, g); end end
module priority_interrupt_controller_tb_top;
  logic clock_i, reset_i, write, read, nmi, usb, ibit, ack, mwr, taken, irq, req, mload;
  logic [4:0] addr;
  logic [7:0] wdata, rdata, vec, gvec;
  logic [6:0] ext;
  logic [39:0] per;
  logic [2:0] mval, cmask, mlev;
  logic [15:0] vaddr, gaddr;
  logic [1:0] dly;
  int n_fail = 0;
  int n_tests = 0;

  pic_controller uut (.clock_i(clock_i), .reset_i(reset_i), .addr_i(addr), .wdata_i(wdata),
    .write_i(write), .read_i(read), .rdata_o(rdata), .nmi_pin_i(nmi), .ext_line_i(ext),
    .usb_line_i(usb), .periph_req_i(per), .core_mask_i(cmask), .core_ibit_i(ibit),
    .ack_i(ack), .req_o(req), .req_nmi_o(), .vec_num_o(vec), .vec_addr_o(vaddr),
    .req_level_o(), .mask_load_o(mload), .mask_level_o(mlev), .irq_o(irq));

  pic_core_model core (.clock_i(clock_i), .reset_i(reset_i), .req_i(req), .vec_i(vec),
    .addr_i(vaddr), .mask_load_i(mload), .mask_level_i(mlev), .delay_i(dly),
    .mask_wr_i(mwr), .mask_val_i(mval), .ack_o(ack), .mask_o(cmask), .taken_o(taken),
    .vec_o(gvec), .addr_o(gaddr));

  // Free-running 100 MHz clock.
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  // Register writes leave one idle edge so the strobe is never driven twice in a step.
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr <= a;
    wdata <= d;
    write <= 1'b1;
    @(posedge clock_i);
    write <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so they are sampled there.
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    @(posedge clock_i);
    addr <= a;
    read <= 1'b1;
    @(posedge clock_i);
    read <= 1'b0;
    #1;
    `CHK("rdata", e, rdata)
  endtask : rd

  // Software on the core rewrites its own mask level.
  task automatic setm(input logic [2:0] m);
    @(posedge clock_i);
    mwr <= 1'b1;
    mval <= m;
    @(posedge clock_i);
    mwr <= 1'b0;
  endtask : setm

  // Waits a bounded time for an acceptance and checks vector, address and new mask.
  task automatic take(input logic want, input logic [7:0] v, input logic [2:0] l);
    int i;
    i = 0;
    while (i < 40 && taken !== 1'b1) begin
      @(posedge clock_i);
      #1;
      i++;
    end
    `CHK("accept", want, logic'(i < 40))
    if (want === 1'b1 && i == 40) stop_test();
    if (i < 40) begin
      `CHK("vector", v, gvec)
      `CHK("address", {6'h00, v, 2'b00}, gaddr)
      repeat (2) @(posedge clock_i);
      #1;
      `CHK("mask", l, cmask)
    end
  endtask : take

  // Main sequence; pins idle high, peripheral requests idle low.
  initial begin
    {addr, wdata, write, read, nmi, per, ibit, mwr, mval, dly} = '0;
    ext = 7'h7F;
    usb = 1'b1;
    reset_i = 1'b1;
    repeat (16) @(posedge clock_i);
    reset_i <= 1'b0;
    for (int r = 0; r < 11; r++) rd(5'(r), 8'h77);
    rd(5'h0B, 8'h00);
    rd(5'h0C, 8'h00);
    rd(5'h0D, 8'h00);
    rd(5'h0E, 8'h02);
    rd(5'h1F, 8'h00);
    wr(5'h00, 8'hFF);
    rd(5'h00, 8'h77);
    $display("Reset values done");
    wr(5'h0B, 8'h01);
    @(posedge clock_i) ibit <= 1'b1;
    @(posedge clock_i) ext[0] <= 1'b0;
    take(1'b0, 8'h00, 3'h7);
    @(posedge clock_i) nmi <= 1'b1;
    take(1'b1, 8'h07, 3'h7);
    `CHK("irq", 1'b0, irq)
    wr(5'h10, 8'h01);
    repeat (2) @(posedge clock_i);
    #1;
    `CHK("irq", 1'b1, irq)
    wr(5'h0F, 8'h01);
    repeat (2) @(posedge clock_i);
    #1;
    `CHK("irq", 1'b0, irq)
    wr(5'h0E, 8'h00);
    @(posedge clock_i) nmi <= 1'b0;
    take(1'b1, 8'h07, 3'h7);
    @(posedge clock_i) ext[0] <= 1'b1;
    wr(5'h0E, 8'h01);
    @(posedge clock_i) ibit <= 1'b0;
    $display("Nonmaskable done");
    @(posedge clock_i) ext[0] <= 1'b0;
    take(1'b0, 8'h00, 3'h7);
    setm(3'h0);
    take(1'b1, 8'h10, 3'h7);
    @(posedge clock_i) ext[0] <= 1'b1;
    wr(5'h00, 8'h07);
    setm(3'h0);
    @(posedge clock_i) ext[0] <= 1'b0;
    take(1'b0, 8'h00, 3'h0);
    setm(3'h3);
    wr(5'h00, 8'h37);
    take(1'b0, 8'h00, 3'h3);
    setm(3'h2);
    take(1'b1, 8'h10, 3'h3);
    @(posedge clock_i) ext[0] <= 1'b1;
    $display("Levels done");
    wr(5'h0B, 8'h40);
    for (int c = 1; c < 4; c++) begin
      wr(5'h0D, 8'(c << 4));
      setm(3'h0);
      @(posedge clock_i) usb <= 1'b0;
      take(logic'(c != 2), 8'h16, 3'h7);
      setm(3'h0);
      @(posedge clock_i) usb <= 1'b1;
      take(logic'(c != 1), 8'h16, 3'h7);
    end
    wr(5'h0D, 8'h10);
    @(posedge clock_i) usb <= 1'b0;
    @(posedge clock_i) usb <= 1'b1;
    take(1'b0, 8'h00, 3'h7);
    setm(3'h0);
    take(1'b1, 8'h16, 3'h7);
    wr(5'h0B, 8'h00);
    @(posedge clock_i) usb <= 1'b0;
    @(posedge clock_i) usb <= 1'b1;
    setm(3'h0);
    take(1'b0, 8'h00, 3'h0);
    $display("Sense codes done");
    wr(5'h02, 8'h72);
    wr(5'h03, 8'h47);
    wr(5'h05, 8'h57);
    @(posedge clock_i) dly <= 2'h3;
    @(posedge clock_i) per <= 40'h0B;
    take(1'b1, 8'h20, 3'h5);
    @(posedge clock_i) per <= 40'h03;
    setm(3'h0);
    take(1'b1, 8'h19, 3'h4);
    @(posedge clock_i) per <= 40'h01;
    setm(3'h0);
    take(1'b1, 8'h18, 3'h2);
    @(posedge clock_i) per <= 40'h00;
    $display("Peripheral priority done");
    stop_test();
  end
endmodule : priority_interrupt_controller_tb_top
